// File: design/swchi_pkg.sv
// constants shared by the switch host port and its buffer
package swchi_pkg;
  // host location decode
  localparam logic [2:0] LOC_INDEX = 3'h0;
  localparam logic [2:0] LOC_INDEX_HIGH = 3'h1;
  localparam logic [2:0] LOC_DATA = 3'h2;
  localparam logic [2:0] LOC_FRAME = 3'h3;
  localparam logic [2:0] LOC_CTRL = 3'h7;
  // index fields
  localparam int IDX_AUTOINC = 15;
  localparam int IDX_PAIRED = 14;
  localparam int IDX_ADDR_W = 12;
  localparam logic [15:0] IDX_RESET = 16'h0000;
  localparam int CFG_DEPTH = 4096;
  // interface modes caught from the strap
  localparam logic [2:0] MODE_BUS16 = 3'h0;
  localparam logic [2:0] MODE_BUS8 = 3'h1;
  localparam logic [2:0] MODE_SER_MII = 3'h2;
  localparam logic [2:0] MODE_SERIAL = 3'h3;
  localparam logic [2:0] MODE_UNMANAGED = 3'h4;
  // frame lengths in bytes
  localparam logic [5:0] CTRL_MAX_BYTES = 6'h28;
  localparam int FRAME_MIN_BYTES = 64;
  // buffer word: bit 8 marks a control-frame byte
  localparam int BUF_W = 9;
  localparam int BUF_DEPTH = 2;
endpackage : swchi_pkg

// File: design/swchi_skid_buf.sv
// two-entry buffer with valid/ready on both sides
module swchi_skid_buf (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  input wire logic clkEn,
  // fill side
  input wire logic [swchi_pkg::BUF_W-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  // drain side
  output logic [swchi_pkg::BUF_W-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  logic [swchi_pkg::BUF_W-1:0] mem [swchi_pkg::BUF_DEPTH];
  logic wrPtr_q;
  logic rdPtr_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign inReady = (cnt_q != 2'h2);
  assign outValid = (cnt_q != 2'h0);
  assign outData = mem[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clk) begin
    if (clkEn && push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (clkEn) begin
      if (push) begin
        wrPtr_q <= ~wrPtr_q;
      end
      if (pop) begin
        rdPtr_q <= ~rdPtr_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // a full buffer never takes a word
  property p_noOverfill;
    @(posedge clk) disable iff (!rstN)
    (cnt_q == 2'h2) |-> !inReady;
  endproperty
  a_noOverfill: assert property (p_noOverfill) else $error("buffer full but ready");
endmodule : swchi_skid_buf

// File: design/swchi_host_port.sv
// host management port: indirect registers, frame locations, reverse MII
module swchi_host_port (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // interface mode strap, caught after reset release
  input wire logic [2:0] modeStrap,
  // host location access from the bus front end
  input wire logic [2:0] busAddr,
  input wire logic busWr,
  input wire logic busRd,
  input wire logic [15:0] busWrData,
  output logic [15:0] busRdData,
  output logic busRdValid,
  output logic busWrBusy,
  // frames and control frames from the host to the switch
  output logic [7:0] ftxByte,
  output logic ftxCtrl,
  output logic ftxValid,
  input wire logic ftxReady,
  // frames for the host, header bytes first
  input wire logic [7:0] frxByte,
  input wire logic frxValid,
  output logic frxReady,
  // control frames for the host
  input wire logic [7:0] crxByte,
  input wire logic crxValid,
  output logic crxReady,
  // host interrupt
  output logic hostIrq,
  // reverse MII, host to switch
  output logic miiRxClk,
  input wire logic miiRxDv,
  input wire logic [3:0] miiRxd,
  output logic [7:0] mrxByte,
  output logic mrxValid,
  output logic mrxLast,
  input wire logic mrxFull,
  // reverse MII, switch to host
  output logic miiTxClk,
  output logic miiTxEn,
  output logic [3:0] miiTxd,
  input wire logic [7:0] mtxByte,
  input wire logic mtxLast,
  input wire logic mtxValid,
  output logic mtxReady
);
  typedef enum logic [1:0] {TX_IDLE, TX_LO, TX_HI, TX_END} swchi_tx_e;

  logic [1:0] rstSync_q, rxDvSync_q;
  logic [2:0] strapSync0_q, strapSync1_q, mode_q;
  logic [15:0] idx_q;
  logic [7:0] cfg [swchi_pkg::CFG_DEPTH];
  logic [11:0] addr, addrNext;
  logic rstN, strapDone_q, isBus8, inBand, isMii;
  logic wrIdx, wrIdxHigh, dataAcc, pairedWr, wrFrame, wrCtrl;
  logic [5:0] ctlTxCnt_q, ctlRxCnt_q;
  logic bufInValid, bufInReady;
  logic [swchi_pkg::BUF_W-1:0] bufOut;
  logic [7:0] cfgRdByte, txB_q;
  logic [3:0] rxdSync0_q, rxdSync1_q, rxLo_q;
  logic rxPh_q, txPh_q, rxDvS, rxHalt, rxRise, rxHaveLo_q, rxDvPrev_q;
  swchi_tx_e txSt_q;
  logic txLast_q, txHalt, txFall, txTake;

  // reset released through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstN = rstSync_q[1];

  // strap pins pass two flops; no reset, so they are settled when reset lifts
  always_ff @(posedge clk) begin
    if (clkEn) begin
      strapSync0_q <= modeStrap;
      strapSync1_q <= strapSync0_q;
    end
  end

  // strap is a static level, caught once after release
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      strapDone_q <= 1'b0;
      mode_q <= swchi_pkg::MODE_BUS16;
    end else if (clkEn && !strapDone_q) begin
      strapDone_q <= 1'b1;
      mode_q <= strapSync1_q;
    end
  end

  assign isBus8 = (mode_q == swchi_pkg::MODE_BUS8);
  assign isMii = (mode_q == swchi_pkg::MODE_SER_MII);
  assign inBand = (mode_q == swchi_pkg::MODE_BUS16) || isBus8 ||
                  (mode_q == swchi_pkg::MODE_SERIAL);

  // access decode
  assign addr = idx_q[swchi_pkg::IDX_ADDR_W-1:0];
  assign wrIdx = busWr && (busAddr == swchi_pkg::LOC_INDEX);
  assign wrIdxHigh = busWr && (busAddr == swchi_pkg::LOC_INDEX_HIGH) && isBus8;
  assign dataAcc = (busWr || busRd) && (busAddr == swchi_pkg::LOC_DATA);
  assign pairedWr = busWr && idx_q[swchi_pkg::IDX_PAIRED] && !isBus8;
  assign addrNext = addr + (pairedWr ? 12'h002 : 12'h001);
  // frames only through the location in parallel or serial-only modes
  assign wrFrame = busWr && (busAddr == swchi_pkg::LOC_FRAME) && inBand;
  assign wrCtrl = busWr && (busAddr == swchi_pkg::LOC_CTRL) &&
                  (mode_q != swchi_pkg::MODE_UNMANAGED) &&
                  (ctlTxCnt_q != swchi_pkg::CTRL_MAX_BYTES);

  // index register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      idx_q <= swchi_pkg::IDX_RESET;
    end else if (clkEn) begin
      if (wrIdx && isBus8) begin
        idx_q[7:0] <= busWrData[7:0];
      end else if (wrIdx) begin
        // reserved bits are kept at zero
        idx_q <= {busWrData[15:14], 2'b00, busWrData[11:0]};
      end else if (wrIdxHigh) begin
        idx_q[15:8] <= {busWrData[7:6], 2'b00, busWrData[3:0]};
      end else if (dataAcc && idx_q[swchi_pkg::IDX_AUTOINC]) begin
        idx_q[11:0] <= addrNext;
      end
    end
  end

  // configuration bank, reached only through the data location
  always_ff @(posedge clk) begin
    if (clkEn && busWr && (busAddr == swchi_pkg::LOC_DATA)) begin
      cfg[addr] <= busWrData[7:0];
      if (pairedWr) begin
        cfg[addr + 12'h001] <= busWrData[15:8];
      end
    end
  end
  assign cfgRdByte = cfg[addr];

  // read answers one cycle after the strobe
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      busRdData <= 16'h0000;
      busRdValid <= 1'b0;
    end else if (clkEn) begin
      busRdValid <= busRd;
      if (busRd) begin
        case (busAddr)
          swchi_pkg::LOC_INDEX: busRdData <= isBus8 ? {8'h00, idx_q[7:0]} : idx_q;
          swchi_pkg::LOC_INDEX_HIGH: busRdData <= {8'h00, idx_q[15:8]};
          swchi_pkg::LOC_DATA: busRdData <= {8'h00, cfgRdByte};
          swchi_pkg::LOC_FRAME: busRdData <= {8'h00, (frxValid && inBand) ? frxByte : 8'h00};
          swchi_pkg::LOC_CTRL: busRdData <= {8'h00, crxReady ? crxByte : 8'h00};
          default: busRdData <= 16'h0000;
        endcase
      end
    end
  end

  // a read of the frame location pops one byte; header bytes arrive first
  assign frxReady = clkEn && busRd && (busAddr == swchi_pkg::LOC_FRAME) && inBand;
  assign crxReady = clkEn && busRd && (busAddr == swchi_pkg::LOC_CTRL) && crxValid &&
                    (mode_q != swchi_pkg::MODE_UNMANAGED) &&
                    (ctlRxCnt_q != swchi_pkg::CTRL_MAX_BYTES);

  // interrupt only where frames travel through the location
  assign hostIrq = frxValid && inBand;

  // control-frame byte counts; a frame-location write restarts the send count, crxValid low the receive count
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ctlTxCnt_q <= 6'h00;
      ctlRxCnt_q <= 6'h00;
    end else if (clkEn) begin
      if (wrCtrl && bufInReady) begin
        ctlTxCnt_q <= ctlTxCnt_q + 6'h01;
      end else if (busWr && busAddr == swchi_pkg::LOC_FRAME) begin
        ctlTxCnt_q <= 6'h00;
      end
      if (crxReady) begin
        ctlRxCnt_q <= ctlRxCnt_q + 6'h01;
      end else if (!crxValid) begin
        ctlRxCnt_q <= 6'h00;
      end
    end
  end

  // control-location bytes go out marked in bit 8 (ftxCtrl), frame-location bytes unmarked
  assign bufInValid = wrFrame || wrCtrl;
  assign busWrBusy = bufInValid && !bufInReady;

  swchi_skid_buf u_txBuf (
    .clk(clk),
    .rstN(rstN),
    .clkEn(clkEn),
    .inData({wrCtrl, busWrData[7:0]}),
    .inValid(bufInValid),
    .inReady(bufInReady),
    .outData(bufOut),
    .outValid(ftxValid),
    .outReady(ftxReady)
  );
  assign ftxByte = bufOut[7:0];
  assign ftxCtrl = bufOut[8];

  // reverse MII receive side: host pins pass two flops first
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rxDvSync_q <= 2'b00;
      rxdSync0_q <= 4'h0;
      rxdSync1_q <= 4'h0;
    end else if (clkEn) begin
      rxDvSync_q <= {rxDvSync_q[0], miiRxDv};
      rxdSync0_q <= miiRxd;
      rxdSync1_q <= rxdSync0_q;
    end
  end
  assign rxDvS = rxDvSync_q[1];

  // the receive clock stands high while the switch FIFO overflows
  assign rxHalt = rxPh_q && mrxFull;
  assign rxRise = !rxPh_q && isMii;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rxPh_q <= 1'b0;
    end else if (clkEn && isMii && !rxHalt) begin
      rxPh_q <= ~rxPh_q;
    end
  end
  assign miiRxClk = rxPh_q;

  // nibbles pair low first into bytes while data valid is high
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rxHaveLo_q <= 1'b0;
      rxDvPrev_q <= 1'b0;
      rxLo_q <= 4'h0;
      mrxByte <= 8'h00;
      mrxValid <= 1'b0;
      mrxLast <= 1'b0;
    end else if (clkEn) begin
      mrxValid <= 1'b0;
      mrxLast <= 1'b0;
      if (rxRise) begin
        rxDvPrev_q <= rxDvS;
        if (rxDvS && !rxHaveLo_q) begin
          rxLo_q <= rxdSync1_q;
          rxHaveLo_q <= 1'b1;
        end else if (rxDvS) begin
          mrxByte <= {rxdSync1_q, rxLo_q};
          mrxValid <= 1'b1;
          rxHaveLo_q <= 1'b0;
        end else begin
          // a lone trailing nibble is dropped
          rxHaveLo_q <= 1'b0;
          mrxLast <= rxDvPrev_q;
        end
      end
    end
  end

  // reverse MII transmit side: the clock stands high on underrun
  assign txHalt = txPh_q && (txSt_q == TX_HI) && !txLast_q && !mtxValid;
  assign txFall = txPh_q && !txHalt && isMii;
  assign txTake = (txSt_q == TX_IDLE) ? (mtxValid && isMii && !txPh_q) :
                  (txFall && txSt_q == TX_HI && !txLast_q && mtxValid);
  assign mtxReady = clkEn && txTake;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      txPh_q <= 1'b0;
    end else if (clkEn && isMii && !txHalt) begin
      txPh_q <= ~txPh_q;
    end
  end
  assign miiTxClk = txPh_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      txSt_q <= TX_IDLE;
      txB_q <= 8'h00;
      txLast_q <= 1'b0;
      miiTxEn <= 1'b0;
      miiTxd <= 4'h0;
    end else if (clkEn) begin
      if (txTake) begin
        txB_q <= mtxByte;
        txLast_q <= mtxLast;
      end
      case (txSt_q)
        TX_IDLE: begin
          if (txTake) begin
            txSt_q <= TX_LO;
          end
        end
        TX_LO: begin
          if (txFall) begin
            miiTxEn <= 1'b1;
            miiTxd <= txB_q[3:0];
            txSt_q <= TX_HI;
          end
        end
        TX_HI: begin
          if (txFall) begin
            miiTxd <= txB_q[7:4];
            txSt_q <= txLast_q ? TX_END : TX_LO;
          end
        end
        TX_END: begin
          if (txFall) begin
            miiTxEn <= 1'b0;
            miiTxd <= 4'h0;
            txSt_q <= TX_IDLE;
          end
        end
        default: txSt_q <= TX_IDLE;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN || !clkEn);

  property p_idxByte;
    (wrIdx && isBus8) |=> (idx_q[7:0] == $past(busWrData[7:0]));
  endproperty
  a_idxByte: assert property (p_idxByte) else $error("index low byte not taken");

  property p_idxWord;
    (wrIdx && !isBus8) |=> (idx_q[11:0] == $past(busWrData[11:0]));
  endproperty
  a_idxWord: assert property (p_idxWord) else $error("index word not taken");

  property p_rsvd;
    idx_q[13:12] == 2'b00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved index bits set");

  property p_inc;
    (dataAcc && idx_q[15] && !pairedWr && !wrIdx) |=> (addr == $past(addr) + 12'h001);
  endproperty
  a_inc: assert property (p_inc) else $error("address did not step");

  sequence s_readData;
    busRd && (busAddr == swchi_pkg::LOC_DATA);
  endsequence
  property p_rdData;
    s_readData |=> busRdValid && (busRdData[7:0] == $past(cfgRdByte));
  endproperty
  a_rdData: assert property (p_rdData) else $error("data read wrong");

  property p_irq;
    hostIrq |-> (frxValid && inBand);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without waiting frame");

  property p_unman;
    (mode_q == swchi_pkg::MODE_UNMANAGED) |-> !hostIrq && !bufInValid && !frxReady;
  endproperty
  a_unman: assert property (p_unman) else $error("frame path open when unmanaged");

  property p_rxHalt;
    (isMii && rxPh_q && mrxFull) |=> miiRxClk;
  endproperty
  a_rxHalt: assert property (p_rxHalt) else $error("receive clock ran during overflow");

  property p_txHalt;
    txHalt |=> miiTxClk;
  endproperty
  a_txHalt: assert property (p_txHalt) else $error("transmit clock ran on underrun");

  sequence s_txStart;
    $rose(miiTxEn);
  endsequence
  property p_txEn;
    s_txStart |-> miiTxEn [*2];
  endproperty
  a_txEn: assert property (p_txEn) else $error("transmit enable dropped early");

  property p_ctlMax;
    ctlTxCnt_q <= swchi_pkg::CTRL_MAX_BYTES && ctlRxCnt_q <= swchi_pkg::CTRL_MAX_BYTES;
  endproperty
  a_ctlMax: assert property (p_ctlMax) else $error("control frame too long");
endmodule : swchi_host_port

// File: dv/swchi_mii_host.sv
// host-side reverse MII model: sends frames on the receive pair, captures the transmit pair
module swchi_mii_host (
  // reverse MII pins
  input wire logic miiRxClk,
  input wire logic miiTxClk,
  input wire logic miiTxEn,
  input wire logic [3:0] miiTxd,
  output logic miiRxDv,
  output logic [3:0] miiRxd,
  // bench control
  input wire logic sendGo,
  input wire logic [7:0] sendLen,
  output logic [7:0] capByte,
  output logic capStrobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] loNib;
  logic half;
  initial begin
    miiRxDv = 1'b0;
    miiRxd = 4'h0;
    capByte = 8'h00;
    capStrobe = 1'b0;
    loNib = 4'h0;
    half = 1'b0;
  end
  // byte i is 8'h30 + i, low nibble first; a halted clock just stalls this loop
  always @(posedge sendGo) begin
    logic [7:0] b;
    for (int i = 0; i < 2 * sendLen; i++) begin
      b = 8'h30 + 8'(i / 2);
      @(posedge miiRxClk);
      miiRxDv = 1'b1;
      miiRxd = i[0] ? b[7:4] : b[3:0];
    end
    @(posedge miiRxClk);
    miiRxDv = 1'b0;
    // released line: no pull, so show the inverse rather than a stale nibble
    miiRxd = ~miiRxd;
  end
  // data is only taken while transmit enable is up
  always @(posedge miiTxClk) begin
    capStrobe = 1'b0;
    if (miiTxEn) begin
      if (half) begin
        capByte = {miiTxd, loNib};
        capStrobe = 1'b1;
      end else begin
        loNib = miiTxd;
      end
      half = ~half;
    end else begin
      half = 1'b0;
    end
  end
endmodule : swchi_mii_host

// File: dv/testbench.sv
// self-checking bench for the switch host port
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, clkEn, busWr, busRd, busRdValid, busWrBusy, ftxCtrl, ftxValid, ftxReady;
  logic frxValid, frxReady, crxValid, crxReady, hostIrq, miiRxClk, miiRxDv, mrxValid, mrxLast;
  logic mrxFull, miiTxClk, miiTxEn, mtxLast, mtxValid, mtxReady, sendGo, capStrobe, ok;
  logic [2:0] modeStrap, busAddr;
  logic [15:0] busWrData, busRdData, v;
  logic [7:0] ftxByte, frxByte, crxByte, mrxByte, mtxByte, sendLen, capByte;
  logic [3:0] miiRxd, miiTxd;
  logic [8:0] ftxQ[$];
  logic [7:0] mrxQ[$], capQ[$];
  int err_total, n_compared, lastCnt, nCtrl;
  swchi_host_port dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .modeStrap(modeStrap),
    .busAddr(busAddr), .busWr(busWr), .busRd(busRd), .busWrData(busWrData),
    .busRdData(busRdData), .busRdValid(busRdValid), .busWrBusy(busWrBusy),
    .ftxByte(ftxByte), .ftxCtrl(ftxCtrl), .ftxValid(ftxValid), .ftxReady(ftxReady),
    .frxByte(frxByte), .frxValid(frxValid), .frxReady(frxReady), .crxByte(crxByte),
    .crxValid(crxValid), .crxReady(crxReady), .hostIrq(hostIrq), .miiRxClk(miiRxClk),
    .miiRxDv(miiRxDv), .miiRxd(miiRxd), .mrxByte(mrxByte), .mrxValid(mrxValid),
    .mrxLast(mrxLast), .mrxFull(mrxFull), .miiTxClk(miiTxClk), .miiTxEn(miiTxEn),
    .miiTxd(miiTxd), .mtxByte(mtxByte), .mtxLast(mtxLast), .mtxValid(mtxValid),
    .mtxReady(mtxReady));
  swchi_mii_host host (.miiRxClk(miiRxClk), .miiTxClk(miiTxClk), .miiTxEn(miiTxEn),
    .miiTxd(miiTxd), .miiRxDv(miiRxDv), .miiRxd(miiRxd), .sendGo(sendGo),
    .sendLen(sendLen), .capByte(capByte), .capStrobe(capStrobe));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (ftxValid && ftxReady) ftxQ.push_back({ftxCtrl, ftxByte});
    if (mrxValid) mrxQ.push_back(mrxByte);
    if (mrxLast) lastCnt++;
  end
  always @(posedge capStrobe) capQ.push_back(capByte);
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic timed_out();
    err_total++;
    complete_run();
  endtask : timed_out
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic do_reset(input logic [2:0] mode);
    rst_n = 1'b0;
    modeStrap = mode;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    // mode is caught at the third edge after release
    repeat (5) @(negedge clk);
    ftxQ.delete();
    mrxQ.delete();
    capQ.delete();
    lastCnt = 0;
  endtask : do_reset
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    busAddr = a;
    busWrData = d;
    busWr = 1'b1;
    @(negedge clk);
    busWr = 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    busAddr = a;
    busRd = 1'b1;
    @(negedge clk);
    busRd = 1'b0;
    for (int i = 0; i < 4 && busRdValid !== 1'b1; i++) @(negedge clk);
    if (busRdValid !== 1'b1) timed_out();
    d = busRdData;
    @(negedge clk);
  endtask : rd
  task automatic wr_frame(input logic [2:0] a, input logic [7:0] d);
    int i;
    busAddr = a;
    busWrData = {8'h00, d};
    busWr = 1'b1;
    // busy only means something while the write stands, so hold it until taken
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (busWrBusy === 1'b0) break;
    end
    if (i == 50) timed_out();
    @(negedge clk);
    busWr = 1'b0;
    @(negedge clk);
  endtask : wr_frame
  task automatic peek(input logic [11:0] a, input logic [7:0] e);
    wr(3'h0, {4'h0, a});
    rd(3'h2, v);
    chk(v, {8'h00, e});
  endtask : peek
  task automatic hold_high(input logic tx);
    ok = 1'b1;
    repeat (6) begin
      @(negedge clk);
      ok = ok & ((tx ? (miiTxClk & miiTxEn) : miiRxClk) === 1'b1);
    end
  endtask : hold_high
  task automatic t_index16();
    do_reset(3'h0);
    chk(miiRxClk, 1'b0);
    wr(3'h0, 16'h8005);
    wr(3'h2, 16'h0012);
    wr(3'h2, 16'h0034);
    peek(12'h005, 8'h12);
    peek(12'h006, 8'h34);
    wr(3'h0, 16'h8005);
    rd(3'h2, v);
    rd(3'h2, v);
    chk(v, 16'h0034);
    wr(3'h0, 16'h4100);
    wr(3'h2, 16'hbbaa);
    peek(12'h100, 8'haa);
    peek(12'h101, 8'hbb);
    wr(3'h0, 16'h3abc);
    rd(3'h0, v);
    chk(v, 16'h0abc);
  endtask : t_index16
  task automatic t_bus8();
    do_reset(3'h1);
    wr(3'h0, 16'h0021);
    wr(3'h1, 16'h0001);
    wr(3'h2, 16'h0022);
    wr(3'h0, 16'h0020);
    wr(3'h1, 16'h0041);
    wr(3'h2, 16'hbbaa);
    wr(3'h1, 16'h0001);
    rd(3'h2, v);
    chk(v, 16'h00aa);
    wr(3'h0, 16'h0021);
    rd(3'h2, v);
    chk(v, 16'h0022);
  endtask : t_bus8
  task automatic t_frames();
    do_reset(3'h0);
    ftxReady = 1'b0;
    wr_frame(3'h3, 8'hf0);
    wr_frame(3'h3, 8'hf1);
    // header byte three meets a full buffer and must wait for a drain
    busAddr = 3'h3;
    busWrData = 16'h00f2;
    busWr = 1'b1;
    @(posedge clk);
    chk(busWrBusy, 1'b1);
    @(negedge clk);
    ftxReady = 1'b1;
    wr_frame(3'h3, 8'hf2);
    for (int i = 0; i < swchi_pkg::FRAME_MIN_BYTES; i++) wr_frame(3'h3, 8'(i));
    repeat (4) @(negedge clk);
    chk(ftxQ.size(), 16'(3 + swchi_pkg::FRAME_MIN_BYTES));
    foreach (ftxQ[i]) chk(ftxQ[i], (i < 3) ? 9'h0f0 + 9'(i) : 9'(i - 3));
    frxValid = 1'b1;
    @(negedge clk);
    chk(hostIrq, 1'b1);
    for (int i = 0; i < 3; i++) begin
      frxByte = 8'h80 + 8'(i);
      rd(3'h3, v);
      chk(v, 16'h0080 + 16'(i));
    end
    frxValid = 1'b0;
    @(negedge clk);
    chk(hostIrq, 1'b0);
    crxValid = 1'b1;
    for (int i = 0; i < 2; i++) begin
      crxByte = 8'hc0 + 8'(i);
      rd(3'h7, v);
      chk(v, 16'h00c0 + 16'(i));
    end
    crxValid = 1'b0;
    for (int i = 0; i < 41; i++) wr_frame(3'h7, 8'(i));
    repeat (4) @(negedge clk);
    nCtrl = 0;
    foreach (ftxQ[i]) nCtrl += ftxQ[i][8];
    chk(nCtrl, 40);
  endtask : t_frames
  task automatic mtx_send(input logic [7:0] b, input logic last);
    int i;
    mtxByte = b;
    mtxLast = last;
    mtxValid = 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (mtxReady === 1'b1) break;
    end
    if (i == 100) timed_out();
    @(negedge clk);
    mtxValid = 1'b0;
  endtask : mtx_send
  task automatic t_mii();
    do_reset(3'h2);
    sendLen = 8'h03;
    sendGo = 1'b1;
    for (int i = 0; i < 400 && lastCnt == 0; i++) @(negedge clk);
    if (lastCnt == 0) timed_out();
    sendGo = 1'b0;
    chk(lastCnt, 1);
    chk(mrxQ.size(), 3);
    foreach (mrxQ[i]) chk(mrxQ[i], 8'h30 + 8'(i));
    wr(3'h3, 16'h0055);
    frxValid = 1'b1;
    repeat (4) @(negedge clk);
    chk(ftxQ.size(), 0);
    chk(hostIrq, 1'b0);
    frxValid = 1'b0;
    wr(3'h0, 16'h0007);
    wr(3'h2, 16'h0066);
    peek(12'h007, 8'h66);
    mrxFull = 1'b1;
    repeat (4) @(negedge clk);
    hold_high(1'b0);
    chk(ok, 1'b1);
    mrxFull = 1'b0;
    mtx_send(8'h5c, 1'b0);
    repeat (12) @(negedge clk);
    hold_high(1'b1);
    chk(ok, 1'b1);
    mtx_send(8'h6d, 1'b1);
    for (int i = 0; i < 100 && capQ.size() < 2; i++) @(negedge clk);
    if (capQ.size() < 2) timed_out();
    chk(capQ.size(), 2);
    foreach (capQ[i]) chk(capQ[i], i ? 8'h6d : 8'h5c);
  endtask : t_mii
  task automatic t_serial();
    do_reset(3'h3);
    wr(3'h0, 16'h4010);
    wr(3'h2, 16'h2211);
    peek(12'h010, 8'h11);
    peek(12'h011, 8'h22);
    wr_frame(3'h3, 8'h77);
    repeat (4) @(negedge clk);
    chk(ftxQ.size(), 1);
    frxValid = 1'b1;
    @(negedge clk);
    chk(hostIrq, 1'b1);
    frxValid = 1'b0;
  endtask : t_serial
  task automatic t_unmanaged();
    do_reset(3'h4);
    wr(3'h3, 16'h0011);
    wr(3'h7, 16'h0022);
    frxValid = 1'b1;
    repeat (4) @(negedge clk);
    chk(ftxQ.size(), 0);
    chk(hostIrq, 1'b0);
    frxValid = 1'b0;
    wr(3'h0, 16'h0009);
    wr(3'h2, 16'h0099);
    peek(12'h009, 8'h99);
  endtask : t_unmanaged
  initial begin
    {clk, busWr, busRd, frxValid, crxValid, mrxFull, mtxLast, mtxValid, sendGo} = '0;
    {busAddr, busWrData, frxByte, crxByte, mtxByte, sendLen} = '0;
    clkEn = 1'b1;
    ftxReady = 1'b1;
    err_total = 0;
    n_compared = 0;
    t_index16();
    t_bus8();
    t_frames();
    t_mii();
    t_serial();
    t_unmanaged();
    complete_run();
  end
endmodule : testbench
